// File: src/wdps_params.svh
// Purpose: Offsets, field positions, reset values and counts of the watchdog timeout select
// Assumes: Included by bare name from the divider and top design files
// Notes:   Definitions only
`ifndef WDPS_PARAMS_SVH
`define WDPS_PARAMS_SVH

// Register word offsets on the plain register port
`define WDPS_ADDR_W          8
`define WDPS_ADDR_CTRL       8'h00
`define WDPS_ADDR_STATUS     8'h04
`define WDPS_ADDR_MASK       8'h08
`define WDPS_ADDR_KICK       8'h0c
`define WDPS_ADDR_COUNT      8'h10

// Control register fields
`define WDPS_CTRL_PS_LSB     0
`define WDPS_CTRL_DIVLO_LSB  4
`define WDPS_CTRL_DIVHI_BIT  6
`define WDPS_CTRL_RUN_BIT    7
`define WDPS_CTRL_EWIE_BIT   8
`define WDPS_CTRL_RST_VAL    32'h0000_0000

// Status and mask fields
`define WDPS_EV_EARLY_BIT    0
`define WDPS_EV_FINAL_BIT    1
`define WDPS_MASK_RST_VAL    2'h0

// Timing
`define WDPS_BASE_CYCLES     2048
`define WDPS_PS_MAX          4'h9
`define WDPS_PS_W            4
`define WDPS_DIV_W           3

`endif

// File: src/wdps_pkg.sv
// Purpose: Types shared by the watchdog timeout select design
// Assumes: Constants live in wdps_params.svh
// Notes:   Nothing is imported; users write wdps_pkg::name
package wdps_pkg;

   typedef enum logic [1:0]
   {
      WDPS_IDLE,
      WDPS_WAIT_EARLY,
      WDPS_WAIT_FINAL
   } wdps_phase_e;

   typedef struct packed
   {
      logic [3:0] cnt;
      logic       tick;
   } wdps_div_s;

endpackage

// File: src/wdps_divider.sv
// Purpose: Divides oscillator ticks by 1, 3, 5 ... 15 into counting-clock enables
// Assumes: tick_in is a one-cycle pulse on clk_sys
// Notes:   A code change takes effect at the next wrap or at once if count passes limit
`timescale 1ns/10ps
`default_nettype none
`include "wdps_params.svh"

module wdps_divider
(
   // Clock and reset
   input  wire logic                   clk_sys,
   input  wire logic                   rst,
   // Divider control
   input  wire logic [`WDPS_DIV_W-1:0] div_code,
   input  wire logic                   tick_in,
   // Divided enable
   output logic                        tick_out
);

   wdps_pkg::wdps_div_s q;
   wdps_pkg::wdps_div_s d;
   logic [3:0]          limit;

   // Divide by 2*code+1
   assign limit = {div_code, 1'b0};

   always_comb
   begin
      d      = q;
      d.tick = 1'b0;
      if (tick_in)
      begin
         if (q.cnt >= limit)
         begin
            d.cnt  = 4'h0;
            d.tick = 1'b1;
         end
         else
         begin
            d.cnt = q.cnt + 4'h1;
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign tick_out = q.tick;

endmodule // wdps_divider
`default_nettype wire

// File: src/wdps_top.sv
// Purpose: Watchdog timeout select: prescaled early warning and final timeout
// Assumes: slow_osc_clock is an asynchronous 128 kHz pin, well below clk_sys
// Notes:   Register port: one-cycle strobes, read data in the following cycle
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "wdps_params.svh"

// Functional notes
// - Early timeout after 2048 shifted by prescale
// - Final timeout after twice the early interval
// - Divider code 1 divides oscillator by three
// - Divider code 2 divides oscillator by five
// - Divider codes give division 1 to 15
// - Early timeout sets flag when enable set
module wdps_top
#(
   parameter int BASE_CYCLES = `WDPS_BASE_CYCLES
)
(
   // Clock and reset
   input  wire logic                    clk_sys,
   input  wire logic                    rst,
   // Oscillator pin
   input  wire logic                    slow_osc_clock,
   // Register port
   input  wire logic [`WDPS_ADDR_W-1:0] reg_addr,
   input  wire logic [31:0]             reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output logic      [31:0]             reg_rdata,
   // Events
   output logic                         wd_count_clock,
   output logic                         early_warning_pulse,
   output logic                         final_timeout_pulse,
   output logic                         irq
);

   localparam int CW = $clog2(BASE_CYCLES) + 12;

   // The count register is read back through a 32-bit word
   if (BASE_CYCLES < 1 || CW > 32)
   begin : g_chk
      $error("BASE_CYCLES must be at least one and its counter fit 32 bits");
   end

   typedef struct packed
   {
      logic                     sync1;
      logic                     sync2;
      logic                     osc_prev;
      wdps_pkg::wdps_phase_e    phase;
      logic [CW-1:0]            cnt;
      logic [`WDPS_PS_W-1:0]    ps;
      logic [`WDPS_DIV_W-1:0]   div;
      logic                     run;
      logic                     ewie;
      logic [1:0]               status;
      logic [1:0]               mask;
      logic [31:0]              rdata;
      logic                     early;
      logic                     final_to;
   } wdps_top_s;

   wdps_top_s     q;
   wdps_top_s     d;
   logic          osc_tick;
   logic          wdt_tick;
   logic [3:0]    ps_eff;
   logic [CW-1:0] period;
   logic [CW-1:0] cnt_inc;
   logic          wr_ctrl;
   logic          wr_status;
   logic          wr_mask;
   logic          wr_kick;
   logic [1:0]    ev_set;

   // Rising edge of the synchronised oscillator
   assign osc_tick = q.sync2 & ~q.osc_prev;

   wdps_divider u_div
   (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .div_code (q.div),
      .tick_in  (osc_tick),
      .tick_out (wdt_tick)
   );

   // Reserved codes clamp to the longest period rather than wrap
   assign ps_eff  = (q.ps > `WDPS_PS_MAX) ? `WDPS_PS_MAX : q.ps;
   assign period  = CW'(BASE_CYCLES) << ps_eff;
   assign cnt_inc = q.cnt + CW'(1);

   assign wr_ctrl   = reg_wr && (reg_addr == `WDPS_ADDR_CTRL);
   assign wr_status = reg_wr && (reg_addr == `WDPS_ADDR_STATUS);
   assign wr_mask   = reg_wr && (reg_addr == `WDPS_ADDR_MASK);
   assign wr_kick   = reg_wr && (reg_addr == `WDPS_ADDR_KICK);

   always_comb
   begin
      d          = q;
      ev_set     = 2'h0;
      d.sync1    = slow_osc_clock;
      d.sync2    = q.sync1;
      d.osc_prev = q.sync2;
      d.early    = 1'b0;
      d.final_to = 1'b0;

      case (q.phase)
         wdps_pkg::WDPS_IDLE:
         begin
            d.cnt = '0;
            if (q.run)
            begin
               d.phase = wdps_pkg::WDPS_WAIT_EARLY;
            end
         end
         wdps_pkg::WDPS_WAIT_EARLY:
         begin
            if (wdt_tick)
            begin
               d.cnt = cnt_inc;
               if (cnt_inc >= period)
               begin
                  d.early = 1'b1;
                  ev_set[`WDPS_EV_EARLY_BIT] = q.ewie;
                  d.phase = wdps_pkg::WDPS_WAIT_FINAL;
               end
            end
         end
         wdps_pkg::WDPS_WAIT_FINAL:
         begin
            if (wdt_tick)
            begin
               d.cnt = cnt_inc;
               if (cnt_inc >= {period[CW-2:0], 1'b0})
               begin
                  d.final_to = 1'b1;
                  ev_set[`WDPS_EV_FINAL_BIT] = 1'b1;
                  d.cnt   = '0;
                  d.phase = wdps_pkg::WDPS_WAIT_EARLY;
               end
            end
         end
         default:
         begin
            d.phase = wdps_pkg::WDPS_IDLE;
         end
      endcase

      // Stopping or kicking restarts the count from zero
      if (!q.run || wr_kick)
      begin
         d.cnt   = '0;
         d.phase = wdps_pkg::WDPS_IDLE;
      end

      if (wr_ctrl)
      begin
         d.ps   = reg_wdata[`WDPS_CTRL_PS_LSB +: `WDPS_PS_W];
         d.div  = {reg_wdata[`WDPS_CTRL_DIVHI_BIT],
                   reg_wdata[`WDPS_CTRL_DIVLO_LSB +: 2]};
         d.run  = reg_wdata[`WDPS_CTRL_RUN_BIT];
         d.ewie = reg_wdata[`WDPS_CTRL_EWIE_BIT];
      end
      if (wr_mask)
      begin
         d.mask = reg_wdata[1:0];
      end

      // Set wins over a same-cycle write-one clear
      d.status = (q.status & ~(wr_status ? reg_wdata[1:0] : 2'h0)) | ev_set;

      d.rdata = 32'h0000_0000;
      if (reg_rd)
      begin
         case (reg_addr)
            `WDPS_ADDR_CTRL:
            begin
               d.rdata[`WDPS_CTRL_PS_LSB +: `WDPS_PS_W]   = q.ps;
               d.rdata[`WDPS_CTRL_DIVLO_LSB +: 2]         = q.div[1:0];
               d.rdata[`WDPS_CTRL_DIVHI_BIT]              = q.div[2];
               d.rdata[`WDPS_CTRL_RUN_BIT]                = q.run;
               d.rdata[`WDPS_CTRL_EWIE_BIT]               = q.ewie;
            end
            `WDPS_ADDR_STATUS:
            begin
               d.rdata[1:0] = q.status;
            end
            `WDPS_ADDR_MASK:
            begin
               d.rdata[1:0] = q.mask;
            end
            `WDPS_ADDR_COUNT:
            begin
               d.rdata[CW-1:0] = q.cnt;
            end
            default:
            begin
               d.rdata = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         q          <= '0;
         q.phase    <= wdps_pkg::WDPS_IDLE;
         q.mask     <= `WDPS_MASK_RST_VAL;
      end
      else
      begin
         q <= d;
      end
   end

   assign reg_rdata           = q.rdata;
   assign wd_count_clock      = wdt_tick;
   assign early_warning_pulse = q.early;
   assign final_timeout_pulse = q.final_to;
   assign irq                 = |(q.status & q.mask);

endmodule // wdps_top
`default_nettype wire

// File: tb/wdps_chk.sv
// Purpose: Port checks of the watchdog timeout select
// Assumes: Oscillator edges at least 9 clk_sys cycles apart
// Notes:   Kick writes only before the early warning
`timescale 1ns/10ps
`default_nettype none
module wdps_chk
#(
   parameter int BASE_CYCLES = 4
)
(
   // Clock and inputs
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   // Outputs
   input wire logic [31:0] reg_rdata,
   input wire logic        wd_count_clock,
   input wire logic        early_warning_pulse,
   input wire logic        final_timeout_pulse,
   input wire logic        irq
);
   logic [3:0] ps_q;
   logic [1:0] mask_q;
   int         tk_q;
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         ps_q   <= 4'h0;
         mask_q <= 2'h0;
         tk_q   <= 0;
      end
      else
      begin
         if (reg_wr && reg_addr == 8'h00)
            ps_q <= (reg_wdata[3:0] > 4'h9) ? 4'h9 : reg_wdata[3:0];
         if (reg_wr && reg_addr == 8'h08)
            mask_q <= reg_wdata[1:0];
         if (early_warning_pulse)
            tk_q <= 0;
         else if (wd_count_clock)
            tk_q <= tk_q + 1;
      end
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   property p_ew_one; early_warning_pulse |=> !early_warning_pulse; endproperty
   property p_fin_one; final_timeout_pulse |=> !final_timeout_pulse; endproperty
   property p_excl; !(early_warning_pulse && final_timeout_pulse); endproperty
   property p_ew_tick; early_warning_pulse |-> $past(wd_count_clock); endproperty
   property p_fin_tick; final_timeout_pulse |-> $past(wd_count_clock); endproperty
   property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
   property p_gap; wd_count_clock |=> !wd_count_clock [*8]; endproperty
   property p_fin_gap; final_timeout_pulse |-> tk_q == (BASE_CYCLES << ps_q); endproperty
   property p_irq_mask; (mask_q == 2'h0 && $past(mask_q) == 2'h0) |-> !irq; endproperty
   a_ew_one: assert property (p_ew_one) else $error("early pulse too long");
   a_fin_one: assert property (p_fin_one) else $error("final pulse too long");
   a_excl: assert property (p_excl) else $error("early and final together");
   a_ew_tick: assert property (p_ew_tick) else $error("early not after tick");
   a_fin_tick: assert property (p_fin_tick) else $error("final not after tick");
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   a_gap: assert property (p_gap) else $error("count ticks too close");
   a_fin_gap: assert property (p_fin_gap) else $error("final interval wrong");
   a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
   c_ew: cover property (early_warning_pulse);
   c_fin: cover property (final_timeout_pulse);
   c_irq: cover property ($rose(irq));
endmodule // wdps_chk
bind wdps_top wdps_chk #(.BASE_CYCLES(BASE_CYCLES)) u_chk (.clk_sys(clk_sys), .rst(rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .wd_count_clock(wd_count_clock),
   .early_warning_pulse(early_warning_pulse), .final_timeout_pulse(final_timeout_pulse),
   .irq(irq));
`default_nettype wire

// File: tb/wdps_top_tb.sv
// Purpose: Random and corner runs of the watchdog timeout select
// Assumes: Oscillator period of 20 clk_sys cycles
// Notes:   Writes aligned away from tick phase so counts are exact
`timescale 1ns/10ps
`default_nettype none
module wdps_top_tb;
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic        osc = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        wclk, ew, fin, irq;
   logic [7:0]  lf = 8'h3c;
   logic [7:0]  ra [5] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h20};
   int          n_fail = 0, samples_checked = 0, tick_n = 0, gap = 0, last_t = 0, cyc = 0;
   initial forever #50 clk_sys = ~clk_sys;
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (cyc % 10 == 9)
         osc <= ~osc;
   end
   always @(negedge clk_sys)
      if (wclk === 1'b1)
      begin
         gap = cyc - last_t;
         last_t = cyc;
         tick_n++;
      end
   wdps_top #(.BASE_CYCLES(4)) dut (.clk_sys(clk_sys), .rst(rst), .slow_osc_clock(osc),
      .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
      .wd_count_clock(wclk), .early_warning_pulse(ew), .final_timeout_pulse(fin), .irq(irq));
   function automatic logic [7:0] nxt(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   task automatic end_sim;
      $display("Checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      @(negedge clk_sys);
      d = rdata;
   endtask
   // Bounded wait: 0 early, 1 final, 2 two ticks
   task automatic wt(input int k);
      int i;
      for (i = 0; i < 10000; i++)
      begin
         @(negedge clk_sys);
         if (k == 0 ? ew === 1'b1 : k == 1 ? fin === 1'b1 : tick_n > 1)
            break;
      end
      if (i == 10000)
      begin
         n_fail++;
         end_sim();
      end
   endtask
   // Keeps writes clear of the tick phase: a kick landing just before a tick
   // would lose that tick in the idle cycle
   task automatic align;
      for (int i = 0; i < 20 && cyc % 20 != 0; i++)
         @(posedge clk_sys);
   endtask
   task automatic run(input logic [3:0] ps, input logic [2:0] d, input logic ie,
                      input logic [1:0] mk);
      logic [31:0] s;
      int          n;
      n = 4 << ps;
      wreg(8'h08, {30'h0, mk});
      align();
      wreg(8'h00, {23'h0, ie, 1'b1, d, ps});
      tick_n = 0;
      wt(2);
      align();
      wreg(8'h0c, 32'h1);
      tick_n = 0;
      wt(0);
      chk(tick_n, n);
      rreg(8'h04, s);
      chk(s, {31'h0, ie});
      rreg(8'h10, s);
      chk(s, n);
      wt(1);
      chk(tick_n, 2 * n);
      chk(gap, (2 * d + 1) * 20);
      rreg(8'h04, s);
      chk(s, {30'h0, 1'b1, ie});
      chk(irq, |({1'b1, ie} & mk));
      wreg(8'h08, 32'h3);
      rreg(8'h08, s);
      chk(s, 32'h3);
      chk(irq, 1'b1);
      wreg(8'h04, 32'h3);
      wreg(8'h00, 32'h0);
      rreg(8'h04, s);
      chk(s, 32'h0);
      chk(irq, 1'b0);
   endtask
   initial
   begin
      logic [31:0] s;
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      wreg(8'h20, 32'hffff_ffff);
      foreach (ra[i])
      begin
         rreg(ra[i], s);
         chk(s, 32'h0);
      end
      // Prescale kept within 0..2
      for (int d = 0; d < 8; d++)
      begin
         lf = nxt(lf);
         run(lf % 3, d, lf[3], lf[5:4]);
      end
      run(4'h4, 3'h0, 1'b1, 2'h0);
      end_sim();
   end
endmodule // wdps_top_tb
`default_nettype wire
